// file: hdl/obcfg_pkg.sv
// Package: option byte layout, defaults and decode encodings
package obcfg_pkg;
    // Byte 0 layout
    localparam int B0_RSVD_HI       = 7;
    localparam int B0_RSVD_LO       = 4;
    localparam int B0_SEC_HI        = 3;
    localparam int B0_SEC_LO        = 2;
    localparam int B0_RDP_BIT       = 1;
    localparam int B0_WRP_BIT       = 0;
    // Byte 1 layout
    localparam int B1_PLLF_BIT      = 7;
    localparam int B1_PLL_BYPASS_BIT    = 6;
    localparam int B1_RSVD_BIT      = 5;
    localparam int B1_OSC_BIT       = 4;
    localparam int B1_BOR_HI        = 3;
    localparam int B1_BOR_LO        = 2;
    localparam int B1_WDSW_BIT      = 1;
    localparam int B1_WDHALT_BIT    = 0;
    // Erased-part defaults
    localparam logic [7:0] BYTE0_DEFAULT = 8'hfc;
    localparam logic [7:0] BYTE1_DEFAULT = 8'hef;
    localparam logic [7:0] BYTE_ERASED   = 8'hff;
    // Sector size codes
    typedef enum logic [1:0] {
        OBCFG_SEC_HALF_K  = 2'h0,
        OBCFG_SEC_ONE_K   = 2'h1,
        OBCFG_SEC_1P5_K   = 2'h2
    } obcfg_sec_t;
    // Brownout threshold encodings
    localparam logic [1:0] BOR_OFF    = 2'h3;
    localparam logic [1:0] BOR_HIGH   = 2'h2;
    localparam logic [1:0] BOR_MEDIUM = 2'h1;
    localparam logic [1:0] BOR_LOW    = 2'h0;
    // Loader sequencer
    typedef enum logic [1:0] {
        OBCFG_IDLE   = 2'h0,
        OBCFG_WIPE   = 2'h1,
        OBCFG_CLEAR  = 2'h3
    } obcfg_state_t;
endpackage

// file: hdl/obcfg_field.sv
// Combinational decode of the two option bytes into settings
`timescale 1ns/10ps
module obcfg_field (
    // Raw bytes
    input  wire logic [7:0] byte0_i,
    input  wire logic [7:0] byte1_i,
    input  wire logic       large_mem_i,
    // Decoded settings
    output wire logic [1:0] first_sector_size_o,
    output wire logic       readout_protect_o,
    output wire logic       write_protect_o,
    output wire logic       pll_factor_select_o,
    output wire logic       pll_bypass_o,
    output wire logic       rc_osc_off_o,
    output wire logic       brownout_enable_o,
    output wire logic [1:0] brownout_threshold_select_o,
    output wire logic       watchdog_software_enable_o,
    output wire logic       watchdog_halt_reset_o
);
    wire logic [1:0] sec_raw;
    assign sec_raw = byte0_i[obcfg_pkg::B0_SEC_HI:obcfg_pkg::B0_SEC_LO];
    // 1x means 1.5k; small parts fall back to 1k since 1.5k does not exist
    assign first_sector_size_o =
        sec_raw[1] ? (large_mem_i ? obcfg_pkg::OBCFG_SEC_1P5_K
                                  : obcfg_pkg::OBCFG_SEC_ONE_K)
                   : sec_raw;
    assign readout_protect_o   = byte0_i[obcfg_pkg::B0_RDP_BIT];
    assign write_protect_o     = byte0_i[obcfg_pkg::B0_WRP_BIT];
    assign pll_factor_select_o = byte1_i[obcfg_pkg::B1_PLLF_BIT];
    assign pll_bypass_o        = byte1_i[obcfg_pkg::B1_PLL_BYPASS_BIT];
    assign rc_osc_off_o        = byte1_i[obcfg_pkg::B1_OSC_BIT];
    assign brownout_threshold_select_o =
        byte1_i[obcfg_pkg::B1_BOR_HI:obcfg_pkg::B1_BOR_LO];
    assign brownout_enable_o =
        brownout_threshold_select_o != obcfg_pkg::BOR_OFF;
    assign watchdog_software_enable_o =
        byte1_i[obcfg_pkg::B1_WDSW_BIT];
    assign watchdog_halt_reset_o = byte1_i[obcfg_pkg::B1_WDHALT_BIT];
endmodule

// file: hdl/obcfg_top.sv
// Option byte store, programming access, and reset-time settings latch
// Notes on behaviour
// - Byte 0 bits 3:2 pick first sector 0.5k, 1k or 1.5k.
// - Byte 0 bit 1 set blocks readout and flash writes.
// - Erasing bytes with readout protection first erases whole memory.
// - Byte 0 bit 0 set locks memory and itself permanently.
// - Option bytes are accessible only in programming mode.
// - Byte 1 bit 7 picks PLL factor four or eight.
// - Byte 1 bit 6 set bypasses the PLL.
// - Byte 1 bit 4 set turns RC oscillator off, external clock used.
// - Byte 1 bits 3:2 select brownout threshold or off.
// - Byte 1 bit 1 selects hardware or software watchdog.
// - Byte 1 bit 0 set makes halt entry reset when watchdog active.
// - Unprogrammed bytes default to fc and ef, oscillator bit zero.
`timescale 1ns/10ps
module obcfg_top #(
    parameter bit LARGE_MEM = 1'b1
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Programming port
    input  wire logic       prog_mode_i,
    input  wire logic       prog_wr_i,
    input  wire logic       prog_erase_i,
    input  wire logic       prog_rd_i,
    input  wire logic       prog_sel_i,
    input  wire logic [7:0] prog_wdata_i,
    output logic      [7:0] prog_rdata_o,
    output wire logic       prog_ack_o,
    output wire logic       prog_refused_o,
    // Program memory erase handshake
    output wire logic       mem_erase_req_o,
    input  wire logic       mem_erase_done_i,
    // Decoded settings
    output logic      [1:0] first_sector_size_o,
    output logic            readout_protect_o,
    output logic            write_protect_o,
    output logic            pll_factor_select_o,
    output logic            pll_bypass_o,
    output logic            rc_osc_off_o,
    output logic            brownout_enable_o,
    output logic      [1:0] brownout_threshold_select_o,
    output logic            watchdog_software_enable_o,
    output logic            watchdog_halt_reset_o
);
    // Non-volatile image; reset_i leaves it alone, nv_init_q loads the shipped state on power-up
    logic [7:0] byte0_q;
    logic [7:0] byte1_q;
    logic       nv_init_q = 1'b0;
    obcfg_pkg::obcfg_state_t state_q;
    obcfg_pkg::obcfg_state_t state_d;

    wire logic [1:0] dec_sec;
    wire logic       dec_rdp;
    wire logic       dec_wrp;
    wire logic       dec_pllf;
    wire logic       dec_pll_bypass;
    wire logic       dec_osc;
    wire logic       dec_boren;
    wire logic [1:0] dec_bor;
    wire logic       dec_wdsw;
    wire logic       dec_wdhalt;

    obcfg_field u_field (
        .byte0_i                     (byte0_q),
        .byte1_i                     (byte1_q),
        .large_mem_i                 (LARGE_MEM),
        .first_sector_size_o         (dec_sec),
        .readout_protect_o           (dec_rdp),
        .write_protect_o             (dec_wrp),
        .pll_factor_select_o         (dec_pllf),
        .pll_bypass_o                (dec_pll_bypass),
        .rc_osc_off_o                (dec_osc),
        .brownout_enable_o           (dec_boren),
        .brownout_threshold_select_o (dec_bor),
        .watchdog_software_enable_o  (dec_wdsw),
        .watchdog_halt_reset_o       (dec_wdhalt)
    );

    // Access qualification
    wire logic access_ok;
    wire logic locked;
    wire logic wr_go;
    wire logic erase_go;
    wire logic rd_go;
    wire logic busy;
    assign busy     = state_q != obcfg_pkg::OBCFG_IDLE;
    assign access_ok = prog_mode_i && !busy;
    assign locked   = byte0_q[obcfg_pkg::B0_WRP_BIT];
    // Erase beats write when both are strobed
    assign erase_go = access_ok && prog_erase_i && !locked;
    assign wr_go    = access_ok && prog_wr_i && !prog_erase_i
                      && !locked;
    assign rd_go    = access_ok && prog_rd_i;
    assign prog_ack_o = erase_go || wr_go || rd_go;
    assign prog_refused_o = (prog_wr_i || prog_erase_i || prog_rd_i)
                            && !prog_ack_o;
    assign mem_erase_req_o = state_q == obcfg_pkg::OBCFG_WIPE;

    // Erase sequencer: wipe memory first when readout protection is set
    always_comb begin
        state_d = state_q;
        case (state_q)
            obcfg_pkg::OBCFG_IDLE: begin
                if (erase_go) begin
                    state_d = dec_rdp ? obcfg_pkg::OBCFG_WIPE
                                      : obcfg_pkg::OBCFG_CLEAR;
                end
            end
            obcfg_pkg::OBCFG_WIPE: begin
                if (mem_erase_done_i) begin
                    state_d = obcfg_pkg::OBCFG_CLEAR;
                end
            end
            obcfg_pkg::OBCFG_CLEAR: begin
                state_d = obcfg_pkg::OBCFG_IDLE;
            end
            default: begin
                state_d = obcfg_pkg::OBCFG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= obcfg_pkg::OBCFG_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Byte store; reserved bits written as given, programmer keeps them 1
    always_ff @(posedge clk_i) begin
        if (!nv_init_q) begin
            nv_init_q <= 1'b1;
            byte0_q   <= obcfg_pkg::BYTE0_DEFAULT;
            byte1_q   <= obcfg_pkg::BYTE1_DEFAULT;
        end else if (state_q == obcfg_pkg::OBCFG_CLEAR) begin
            // All-ones would set the lock bit; erase must leave it writable
            byte0_q <= obcfg_pkg::BYTE0_DEFAULT;
            byte1_q <= obcfg_pkg::BYTE1_DEFAULT;
        end else if (wr_go && !prog_sel_i) begin
            byte0_q <= prog_wdata_i;
        end else if (wr_go && prog_sel_i) begin
            byte1_q <= prog_wdata_i;
        end
    end

    // Read data only while access is granted
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prog_rdata_o <= 8'h00;
        end else if (rd_go) begin
            prog_rdata_o <= prog_sel_i ? byte1_q : byte0_q;
        end
    end

    // Settings follow the store only while reset is held
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_sector_size_o         <= dec_sec;
            readout_protect_o           <= dec_rdp;
            write_protect_o             <= dec_wrp;
            pll_factor_select_o         <= dec_pllf;
            pll_bypass_o                <= dec_pll_bypass;
            rc_osc_off_o                <= dec_osc;
            brownout_enable_o           <= dec_boren;
            brownout_threshold_select_o <= dec_bor;
            watchdog_software_enable_o  <= dec_wdsw;
            watchdog_halt_reset_o       <= dec_wdhalt;
        end
    end
endmodule

// file: bench/obcfg_chk_sva.sv
// Port-level assertions for the option byte loader
`timescale 1ns/10ps
module obcfg_chk (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       prog_mode_i,
    input wire logic       prog_rd_i,
    input wire logic       prog_wr_i,
    input wire logic       prog_erase_i,
    input wire logic       prog_ack_o,
    input wire logic       prog_refused_o,
    input wire logic       mem_erase_req_o,
    input wire logic       mem_erase_done_i,
    input wire logic [1:0] first_sector_size_o,
    input wire logic       brownout_enable_o,
    input wire logic [1:0] brownout_threshold_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic strobe = prog_rd_i | prog_wr_i | prog_erase_i;
    property p_mode; strobe && !prog_mode_i |-> prog_refused_o; endproperty
    a_mode: assert property (p_mode) else $error("strobe not refused");
    property p_ack; prog_ack_o |-> prog_mode_i && strobe; endproperty
    a_ack: assert property (p_ack) else $error("ack without request");
    property p_hold;
        !$past(reset_i) |-> $stable({first_sector_size_o,
            brownout_enable_o, brownout_threshold_select_o});
    endproperty
    a_hold: assert property (p_hold) else $error("settings moved");
    property p_bor;
        brownout_enable_o == (brownout_threshold_select_o != 2'h3);
    endproperty
    a_bor: assert property (p_bor) else $error("brownout enable wrong");
    property p_sec; first_sector_size_o != 2'h3; endproperty
    a_sec: assert property (p_sec) else $error("bad sector code");
    property p_rise;
        $rose(mem_erase_req_o) |-> $past(prog_erase_i && prog_ack_o);
    endproperty
    a_rise: assert property (p_rise) else $error("erase req uncaused");
    property p_wait; mem_erase_req_o && !mem_erase_done_i |=> mem_erase_req_o;
    endproperty
    a_wait: assert property (p_wait) else $error("erase req dropped");
    property p_drop; mem_erase_req_o && mem_erase_done_i |=> !mem_erase_req_o;
    endproperty
    a_drop: assert property (p_drop) else $error("erase req stuck");
    property p_busy; mem_erase_req_o && strobe |-> prog_refused_o; endproperty
    a_busy: assert property (p_busy) else $error("busy not refused");
    c_erase: cover property (mem_erase_req_o && mem_erase_done_i);
    c_refuse: cover property (prog_refused_o);
    c_ack: cover property (prog_ack_o && prog_wr_i);
endmodule
bind obcfg_top obcfg_chk u_chk (.clk_i(clk_i), .reset_i(reset_i),
    .prog_mode_i(prog_mode_i), .prog_rd_i(prog_rd_i), .prog_wr_i(prog_wr_i),
    .prog_erase_i(prog_erase_i), .prog_ack_o(prog_ack_o),
    .prog_refused_o(prog_refused_o), .mem_erase_req_o(mem_erase_req_o),
    .mem_erase_done_i(mem_erase_done_i),
    .first_sector_size_o(first_sector_size_o),
    .brownout_enable_o(brownout_enable_o),
    .brownout_threshold_select_o(brownout_threshold_select_o));

// file: bench/obcfg_prog.sv
// Programming tool model driving the option byte port
`timescale 1ns/10ps
module obcfg_prog (
    input  wire logic       clk_i,
    input  wire logic       ack_i,
    output logic            mode_o = 1'b0,
    output logic            rd_o = 1'b0,
    output logic            wr_o = 1'b0,
    output logic            erase_o = 1'b0,
    output logic            sel_o = 1'b0,
    output logic      [7:0] wdata_o = 8'h00
);
    task automatic set_mode(input logic m);
        @(posedge clk_i);
        mode_o <= m;
    endtask
    // One strobe cycle; released strobes drop to 0, sel and data show the inverse of the last value
    task automatic xfer(input logic [1:0] kind, input logic sel,
                        input logic [7:0] data, output logic ok);
        @(posedge clk_i);
        rd_o    <= (kind == 2'h0);
        wr_o    <= (kind == 2'h1);
        erase_o <= (kind == 2'h2);
        sel_o   <= sel;
        wdata_o <= sel ? (data | 8'h20) : (data | 8'hf0);
        @(posedge clk_i);
        ok = ack_i;
        {rd_o, wr_o, erase_o} <= 3'h0;
        sel_o   <= ~sel;
        wdata_o <= ~wdata_o;
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the option byte loader
`timescale 1ns/10ps
module tb;
    logic            clk_i = 1'b0;
    logic            reset_i = 1'b1;
    logic            mem_done = 1'b0;
    logic            ok;
    logic      [7:0] p0 = 8'hfc;
    logic      [7:0] p1 = 8'hef;
    logic      [7:0] tb0 [4] = '{8'hf4, 8'hf0, 8'hf8, 8'hfc};
    logic      [7:0] tb1 [4] = '{8'h28, 8'h25, 8'hb3, 8'hf2};
    wire logic       ack, mode, rd, wr, er, sel, req, rdp, wrp, pf, pb, osc;
    wire logic       bore, wsw, wh;
    wire logic [7:0] wd, rdo;
    wire logic [1:0] sec, bor, sec_sm;
    int              err_total = 0;
    int              cmp_count = 0;
    always #5 clk_i = ~clk_i;
    obcfg_prog u_prog (.clk_i(clk_i), .ack_i(ack), .mode_o(mode), .rd_o(rd),
        .wr_o(wr), .erase_o(er), .sel_o(sel), .wdata_o(wd));
    obcfg_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .prog_mode_i(mode),
        .prog_wr_i(wr), .prog_erase_i(er), .prog_rd_i(rd), .prog_sel_i(sel),
        .prog_wdata_i(wd), .prog_rdata_o(rdo), .prog_ack_o(ack),
        .prog_refused_o(), .mem_erase_req_o(req), .mem_erase_done_i(mem_done),
        .first_sector_size_o(sec), .readout_protect_o(rdp),
        .write_protect_o(wrp), .pll_factor_select_o(pf), .pll_bypass_o(pb),
        .rc_osc_off_o(osc), .brownout_enable_o(bore),
        .brownout_threshold_select_o(bor), .watchdog_software_enable_o(wsw),
        .watchdog_halt_reset_o(wh));
    // Small-memory variant on the same port; only its sector decode differs
    obcfg_top #(.LARGE_MEM(1'b0)) u_dut_sm (.clk_i(clk_i), .reset_i(reset_i),
        .prog_mode_i(mode), .prog_wr_i(wr), .prog_erase_i(er), .prog_rd_i(rd),
        .prog_sel_i(sel), .prog_wdata_i(wd), .prog_rdata_o(),
        .prog_ack_o(), .prog_refused_o(), .mem_erase_req_o(),
        .mem_erase_done_i(mem_done), .first_sector_size_o(sec_sm),
        .readout_protect_o(), .write_protect_o(), .pll_factor_select_o(),
        .pll_bypass_o(), .rc_osc_off_o(), .brownout_enable_o(),
        .brownout_threshold_select_o(), .watchdog_software_enable_o(),
        .watchdog_halt_reset_o());
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic s, input logic [7:0] exp);
        u_prog.xfer(2'h0, s, 8'h00, ok);
        #1;
        cmp("read ack", 8'h01, {7'h0, ok});
        cmp("read data", exp, rdo);
    endtask
    task automatic dec_chk(input logic [7:0] b0, b1);
        cmp("sector", {6'h0, b0[3] ? 2'h2 : b0[3:2]}, {6'h0, sec});
        cmp("small sector", {6'h0, b0[3] ? 2'h1 : b0[3:2]},
            {6'h0, sec_sm});
        cmp("protect", {6'h0, b0[1:0]}, {6'h0, rdp, wrp});
        cmp("clock", {5'h0, b1[7:6], b1[4]},
            {5'h0, pf, pb, osc});
        cmp("brownout", {5'h0, b1[3:2] != 2'h3, b1[3:2]},
            {5'h0, bore, bor});
        cmp("watchdog", {6'h0, b1[1:0]}, {6'h0, wsw, wh});
    endtask
    task automatic pulse_rst;
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wait_req(input logic lvl);
        #1;
        for (int i = 0; i < 20 && req !== lvl; i++) begin
            @(posedge clk_i);
            #1;
        end
        cmp("erase request", {7'h0, lvl}, {7'h0, req});
        if (req !== lvl) complete_run();
    endtask
    task automatic t_apply(input logic [7:0] b0, b1);
        u_prog.xfer(2'h1, 1'b0, b0, ok);
        u_prog.xfer(2'h1, 1'b1, b1, ok);
        rd_chk(1'b0, b0 | 8'hf0);
        rd_chk(1'b1, b1 | 8'h20);
        dec_chk(p0, p1);
        pulse_rst();
        p0 = b0 | 8'hf0;
        p1 = b1 | 8'h20;
        dec_chk(p0, p1);
    endtask
    // Protected erase wipes memory first, then the part is writable again
    task automatic t_erase;
        u_prog.xfer(2'h1, 1'b0, 8'hf6, ok);
        pulse_rst();
        dec_chk(8'hf6, p1);
        u_prog.xfer(2'h2, 1'b0, 8'h00, ok);
        wait_req(1'b1);
        u_prog.xfer(2'h0, 1'b1, 8'h00, ok);
        cmp("busy read ack", 8'h00, {7'h0, ok});
        @(posedge clk_i);
        mem_done <= 1'b1;
        @(posedge clk_i);
        mem_done <= 1'b0;
        wait_req(1'b0);
        rd_chk(1'b0, 8'hfc);
        rd_chk(1'b1, 8'hef);
        u_prog.xfer(2'h1, 1'b0, 8'h04, ok);
        cmp("reprogram ack", 8'h01, {7'h0, ok});
        u_prog.xfer(2'h2, 1'b0, 8'h00, ok);
        cmp("plain erase ack", 8'h01, {7'h0, ok});
        rd_chk(1'b0, 8'hfc);
        u_prog.xfer(2'h1, 1'b0, 8'h03, ok);
        u_prog.xfer(2'h1, 1'b0, 8'h00, ok);
        cmp("locked write ack", 8'h00, {7'h0, ok});
        u_prog.xfer(2'h2, 1'b0, 8'h00, ok);
        cmp("locked erase ack", 8'h00, {7'h0, ok});
        rd_chk(1'b0, 8'hf3);
        pulse_rst();
        dec_chk(8'hf3, 8'hef);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        u_prog.xfer(2'h0, 1'b0, 8'h00, ok);
        cmp("idle mode read ack", 8'h00, {7'h0, ok});
        u_prog.set_mode(1'b1);
        rd_chk(1'b0, 8'hfc);
        rd_chk(1'b1, 8'hef);
        dec_chk(8'hfc, 8'hef);
        for (int i = 0; i < 4; i++) t_apply(tb0[i], tb1[i]);
        t_erase();
        complete_run();
    end
endmodule
